// ---- core/ifpl_regs.svh ----
/*
 * register offsets, field positions and reset values of the force-pending bank.
 * assumes inclusion by bare name from the package and the modules.
 */
`ifndef IFPL_REGS_SVH
`define IFPL_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IFPL_OFF_FORCE_PEND 8'h00
`define IFPL_OFF_CLEAR_PEND 8'h04
`define IFPL_OFF_ENABLE_SET 8'h08
`define IFPL_OFF_ENABLE_CLR 8'h0c
`define IFPL_OFF_EVT_STATUS 8'h10
`define IFPL_OFF_EVT_MASK 8'h14
`define IFPL_OFF_SRC_LEVEL 8'h18

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define IFPL_IMPL_MASK 32'hffff8fff
`define IFPL_EVT_PEND_BIT 0
`define IFPL_EVT_DROP_BIT 1
`define IFPL_EVT_WIDTH 2
`define IFPL_PEND_RST 32'h00000000
`define IFPL_EN_RST 32'h00000000
`define IFPL_MASK_RST 2'h0

`endif

// ---- core/ifpl_pkg.sv ----
/*
 * types shared by the force-pending bank modules.
 * assumes ifpl_regs.svh on the include path.
 */
`include "ifpl_regs.svh"

package ifpl_pkg;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef logic [31:0] ifpl_word_type;
    typedef logic [7:0] ifpl_addr_type;
    typedef logic [`IFPL_EVT_WIDTH-1:0] ifpl_evt_type;
endpackage : ifpl_pkg

// ---- core/ifpl_pend_if.sv ----
/*
 * carrier between register decode and the pending-state array.
 * assumes one clock domain.
 */
interface ifpl_pend_if;
    import ifpl_pkg::*;
    ifpl_word_type set_req; // one-cycle force-pending write data
    ifpl_word_type clr_req; // one-cycle clear-pending write data
    ifpl_word_type enabled; // live enable state
    ifpl_word_type pend; // live pending state
    ifpl_word_type newly; // bits a force write pends at this edge
    ifpl_word_type refused; // ones written but not taken

    modport ctl (output set_req, output clr_req, output enabled,
                 input pend, input newly, input refused);
    modport arr (input set_req, input clr_req, input enabled,
                 output pend, output newly, output refused);
endinterface : ifpl_pend_if

// ---- core/ifpl_sync.sv ----
/*
 * two-flop synchroniser for the external interrupt source levels.
 * assumes sources are asynchronous to clk_in.
 */
`include "ifpl_regs.svh"

module ifpl_sync
    import ifpl_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk_in, // system clock
    input wire logic rst_b_in, // async reset, active low
    input wire logic ce_in, // clock enable
    input wire logic [WIDTH-1:0] async_in, // raw levels
    output logic [WIDTH-1:0] sync_out // synchronised levels
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ------------------------------------------------------------------
    // two flops; first flop read only by the second
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce_in) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : ifpl_sync

// ---- core/ifpl_pend_array.sv ----
/*
 * per-interrupt pending flops with force and clear.
 * assumes set/clear requests are single-cycle and masked to implemented bits.
 */
`include "ifpl_regs.svh"

module ifpl_pend_array
    import ifpl_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic rst_b_in, // async reset, active low
    input wire logic ce_in, // clock enable
    input wire logic [31:0] src_in, // synchronised source levels
    ifpl_pend_if.arr pif // request and state carrier
);
    localparam logic [31:0] IMPL = `IFPL_IMPL_MASK;
    logic [31:0] pend_ff;

    // ------------------------------------------------------------------
    // one pending flop per implemented line
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 32; i++) begin : g_bit
        if (IMPL[i]) begin : g_impl
            logic take;
            // force only when idle and enabled
            assign take = pif.set_req[i] && !pend_ff[i] && pif.enabled[i]; // see [RULE3]
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    pend_ff[i] <= 1'b0;
                end else if (ce_in) begin
                    if (take || (src_in[i] && pif.enabled[i])) begin
                        pend_ff[i] <= 1'b1; // see [RULE2]
                    end else if (pif.clr_req[i]) begin
                        pend_ff[i] <= 1'b0; // see [RULE6]
                    end
                end
            end
            assign pif.newly[i] = take;
            assign pif.refused[i] = pif.set_req[i] && !take;
        end else begin : g_rsvd
            // reserved slot holds nothing
            assign pend_ff[i] = 1'b0; // see [RULE8]
            assign pif.newly[i] = 1'b0;
            assign pif.refused[i] = 1'b0;
        end
    end

    assign pif.pend = pend_ff; // see [RULE5]
endmodule : ifpl_pend_array

// ---- core/ifpl_bank.sv ----
/*
 * force-pending register bank for interrupt lines 31..15 and 11..0,
 * with enable set/clear, clear-pending, event status, mask and irq out.
 * assumes a single-cycle strobe register port on clk_in.
 */
// Strobed register access and the register offsets were left to the implementer.
// Operation
// [RULE1] bit n of the force-pending word serves interrupt n; 31..15 and 11..0
// [RULE2] writing one to an implemented force bit pends that interrupt
// [RULE3] writing one is ignored if already pending or the line is disabled
// [RULE4] writing zero to a force bit changes nothing
// [RULE5] reading the force word returns live pending state
// [RULE6] writing one to the clear-pending bit clears the pending state; here an enabled line whose source level is high stays pending
// [RULE7] writing one to enable-clear disables the line; zero leaves it
// [RULE8] bits 14..12 reserved: software writes zero, device holds and ignores
`include "ifpl_regs.svh"

module ifpl_bank
    import ifpl_pkg::*;
(
    input wire logic clk_in, // system clock, 100 MHz
    input wire logic rst_b_in, // async reset, active low
    input wire logic ce_in, // clock enable, freezes state when low
    input wire logic [7:0] addr_in, // register byte address
    input wire logic [31:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [31:0] irq_src_in, // asynchronous source levels
    output logic [31:0] rdata_out, // read data, cycle after strobe
    output logic [31:0] pend_out, // live pending state
    output logic irq_out // level, high on unmasked event
);
    localparam ifpl_word_type IMPL = `IFPL_IMPL_MASK;

    ifpl_pend_if pif ();
    ifpl_word_type src_sync;
    ifpl_word_type en_ff;
    ifpl_word_type rdata_ff;
    ifpl_evt_type evt_ff;
    ifpl_evt_type mask_ff;
    ifpl_word_type nxt_rdata;
    logic wr_force;
    logic wr_clrp;
    logic wr_ens;
    logic wr_enc;
    logic wr_stat;
    logic wr_mask;

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    ifpl_sync #(.WIDTH(32)) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .async_in(irq_src_in),
        .sync_out(src_sync)
    );

    ifpl_pend_array u_arr (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .src_in(src_sync & IMPL),
        .pif(pif)
    );

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign wr_force = wr_in && (addr_in == `IFPL_OFF_FORCE_PEND);
    assign wr_clrp = wr_in && (addr_in == `IFPL_OFF_CLEAR_PEND);
    assign wr_ens = wr_in && (addr_in == `IFPL_OFF_ENABLE_SET);
    assign wr_enc = wr_in && (addr_in == `IFPL_OFF_ENABLE_CLR);
    assign wr_stat = wr_in && (addr_in == `IFPL_OFF_EVT_STATUS);
    assign wr_mask = wr_in && (addr_in == `IFPL_OFF_EVT_MASK);

    // zeros and reserved bits carry no request
    assign pif.set_req = (wr_force && ce_in) ? (wdata_in & IMPL) : '0; // see [RULE1] [RULE4] [RULE8]
    assign pif.clr_req = (wr_clrp && ce_in) ? (wdata_in & IMPL) : '0; // see [RULE6]
    assign pif.enabled = en_ff;

    // ------------------------------------------------------------------
    // enable state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_ff <= `IFPL_EN_RST;
        end else if (ce_in) begin
            if (wr_ens) begin
                en_ff <= en_ff | (wdata_in & IMPL);
            end else if (wr_enc) begin
                en_ff <= en_ff & ~(wdata_in & IMPL); // see [RULE7]
            end
        end
    end

    // ------------------------------------------------------------------
    // event status: set wins over write-one clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evt_ff <= '0;
        end else if (ce_in) begin
            evt_ff[`IFPL_EVT_PEND_BIT] <= (|pif.newly) ||
                (evt_ff[`IFPL_EVT_PEND_BIT] && !(wr_stat && wdata_in[`IFPL_EVT_PEND_BIT]));
            evt_ff[`IFPL_EVT_DROP_BIT] <= (|pif.refused) ||
                (evt_ff[`IFPL_EVT_DROP_BIT] && !(wr_stat && wdata_in[`IFPL_EVT_DROP_BIT]));
        end
    end

    // mask register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mask_ff <= `IFPL_MASK_RST;
        end else if (ce_in && wr_mask) begin
            mask_ff <= wdata_in[`IFPL_EVT_WIDTH-1:0];
        end
    end

    assign irq_out = |(evt_ff & mask_ff);

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = '0;
        if (addr_in == `IFPL_OFF_FORCE_PEND) begin
            nxt_rdata = pif.pend; // see [RULE5]
        end else if (addr_in == `IFPL_OFF_CLEAR_PEND) begin
            nxt_rdata = pif.pend;
        end else if (addr_in == `IFPL_OFF_ENABLE_SET) begin
            nxt_rdata = en_ff;
        end else if (addr_in == `IFPL_OFF_ENABLE_CLR) begin
            nxt_rdata = en_ff;
        end else if (addr_in == `IFPL_OFF_EVT_STATUS) begin
            nxt_rdata = {30'h0, evt_ff};
        end else if (addr_in == `IFPL_OFF_EVT_MASK) begin
            nxt_rdata = {30'h0, mask_ff};
        end else if (addr_in == `IFPL_OFF_SRC_LEVEL) begin
            nxt_rdata = src_sync & IMPL;
        end
    end

    // read data register, zero outside a read
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_ff <= '0;
        end else if (ce_in) begin
            rdata_ff <= rd_in ? nxt_rdata : '0;
        end
    end

    assign rdata_out = rdata_ff;
    assign pend_out = pif.pend;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    rsvd_never_pend_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE8]
        (pend_out[14:12] == 3'h0))
        else $error("reserved pending bit set");

    force_pends_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE2]
        (ce_in && wr_force && (wdata_in[0] & en_ff[0]) && !wr_clrp) |=> pend_out[0])
        else $error("force write did not pend line 0");

    disabled_ignored_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE3]
        (ce_in && wr_force && !en_ff[20] && !pend_out[20] && !src_sync[20])
        |=> !pend_out[20])
        else $error("disabled line was pended");

    zero_write_nop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE4]
        (ce_in && wr_force && !wdata_in[5] && !src_sync[5]) |=> (pend_out[5] == $past(pend_out[5])))
        else $error("zero write changed pending");

    read_live_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE5]
        (ce_in && rd_in && addr_in == `IFPL_OFF_FORCE_PEND) |=> (rdata_out == $past(pend_out)))
        else $error("read did not return pending state");

    clear_pend_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE6]
        (ce_in && wr_clrp && wdata_in[31] && !wr_force && !src_sync[31]) |=> !pend_out[31])
        else $error("clear-pending write ignored");

    enable_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE7]
        (ce_in && wr_enc && wdata_in[3]) |=> !en_ff[3])
        else $error("enable clear ignored");

    bit_map_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE1]
        (ce_in && wr_force && wdata_in == 32'h00008000 && en_ff[15] && !pend_out[15] && !wr_clrp)
        |=> (pend_out[15] && evt_ff[`IFPL_EVT_PEND_BIT]))
        else $error("bit 15 not mapped to line 15");

    rsvd_write_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // see [RULE8]
        (ce_in && wr_force && ((wdata_in & IMPL) == '0) && (evt_ff == '0)) |=> (evt_ff == '0))
        else $error("reserved-only write raised an event");
endmodule : ifpl_bank

// ---- tb/ifpl_bank_tb.sv ----
/*
 * self-checking bench for the force-pending register bank.
 * assumes core/ on the include path and ifpl_pkg compiled before this file.
 */
`include "ifpl_regs.svh"
`define CHK(got, exp) check(got, exp)

module ifpl_bank_tb
    import ifpl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------------
    logic clk_in;
    logic rst_b_in;
    logic ce_in;
    logic wr_in;
    logic rd_in;
    logic irq_out;
    ifpl_addr_type addr_in;
    ifpl_word_type wdata_in;
    ifpl_word_type irq_src_in;
    ifpl_word_type rdata_out;
    ifpl_word_type pend_out;
    ifpl_word_type rd_val;
    int num_errors;
    int checked;

    ifpl_bank u_ifpl_bank (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .irq_src_in(irq_src_in),
        .rdata_out(rdata_out),
        .pend_out(pend_out),
        .irq_out(irq_out)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    // compare and count, report at once on mismatch
    task automatic check(input ifpl_word_type got, input ifpl_word_type exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one-cycle write; returns just after the edge that takes it
    task automatic reg_wr(input ifpl_addr_type a, input ifpl_word_type d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : reg_wr

    // one-cycle read; data sampled in the cycle after the strobe
    task automatic reg_rd(input ifpl_addr_type a, output ifpl_word_type d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : reg_rd

    // irq level one edge later, after status and mask flops settle
    task automatic irq_is(input logic exp);
        @(posedge clk_in);
        #1;
        `CHK({31'h0, irq_out}, {31'h0, exp});
    endtask : irq_is

    task automatic summarize();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // state straight out of reset: nothing pending, all disabled
    task automatic t_reset();
        reg_rd(`IFPL_OFF_FORCE_PEND, rd_val);
        `CHK(rd_val, `IFPL_PEND_RST);
        reg_rd(`IFPL_OFF_ENABLE_SET, rd_val);
        `CHK(rd_val, `IFPL_EN_RST);
        `CHK({31'h0, irq_out}, 32'h00000000);
    endtask : t_reset

    // ones on disabled lines are refused and flagged
    task automatic t_refuse_disabled();
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'hffffffff);
        `CHK(pend_out, 32'h00000000);
        reg_rd(`IFPL_OFF_EVT_STATUS, rd_val);
        `CHK(rd_val & 32'h3, 32'h00000002);
        reg_wr(`IFPL_OFF_EVT_STATUS, 32'h00000003);
        reg_rd(`IFPL_OFF_EVT_STATUS, rd_val);
        `CHK(rd_val & 32'h3, 32'h00000000);
    endtask : t_refuse_disabled

    // each bit forced, read back and cleared on its own
    task automatic t_walk();
        ifpl_word_type one;
        reg_wr(`IFPL_OFF_ENABLE_SET, 32'hffffffff);
        for (int i = 0; i < 32; i++) begin
            one = 32'h1 << i;
            reg_wr(`IFPL_OFF_FORCE_PEND, one);
            `CHK(pend_out, one & `IFPL_IMPL_MASK);
            reg_rd(`IFPL_OFF_FORCE_PEND, rd_val);
            `CHK(rd_val, one & `IFPL_IMPL_MASK);
            reg_wr(`IFPL_OFF_CLEAR_PEND, one);
            `CHK(pend_out, 32'h00000000);
        end
    endtask : t_walk

    // zero writes, reserved-only writes and repeat ones leave pending alone
    task automatic t_zero_repeat();
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'h80008001);
        reg_wr(`IFPL_OFF_EVT_STATUS, 32'h00000003);
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'h00000000);
        `CHK(pend_out, 32'h80008001);
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'h00007000);
        `CHK(pend_out, 32'h80008001);
        reg_rd(`IFPL_OFF_EVT_STATUS, rd_val);
        `CHK(rd_val & 32'h3, 32'h00000000);
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'h80000000);
        `CHK(pend_out, 32'h80008001);
        reg_rd(`IFPL_OFF_EVT_STATUS, rd_val);
        `CHK(rd_val & 32'h3, 32'h00000002);
        // read data fall back to zero one cycle later
        @(posedge clk_in);
        #1;
        `CHK(rdata_out, 32'h00000000);
        reg_wr(`IFPL_OFF_CLEAR_PEND, 32'h80008001);
        reg_rd(`IFPL_OFF_FORCE_PEND, rd_val);
        `CHK(rd_val, 32'h00000000);
        reg_wr(`IFPL_OFF_EVT_STATUS, 32'h00000003);
    endtask : t_zero_repeat

    // enable-clear: zero keeps, one disables and blocks forcing
    task automatic t_enable_clear();
        reg_wr(`IFPL_OFF_ENABLE_CLR, 32'h00000000);
        reg_rd(`IFPL_OFF_ENABLE_SET, rd_val);
        `CHK(rd_val & `IFPL_IMPL_MASK, `IFPL_IMPL_MASK);
        reg_wr(`IFPL_OFF_ENABLE_CLR, 32'h00000009);
        reg_rd(`IFPL_OFF_ENABLE_CLR, rd_val);
        `CHK(rd_val & `IFPL_IMPL_MASK, `IFPL_IMPL_MASK & 32'hfffffff6);
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'h00000003);
        `CHK(pend_out, 32'h00000002);
        reg_wr(`IFPL_OFF_CLEAR_PEND, 32'h00000002);
        reg_wr(`IFPL_OFF_EVT_STATUS, 32'h00000003);
    endtask : t_enable_clear

    // clock enable low: writes are not taken and nothing moves
    task automatic t_freeze();
        @(posedge clk_in);
        ce_in <= 1'b0;
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'h00000010);
        `CHK(pend_out, 32'h00000000);
        reg_wr(`IFPL_OFF_EVT_MASK, 32'h00000003);
        @(posedge clk_in);
        ce_in <= 1'b1;
        reg_rd(`IFPL_OFF_EVT_MASK, rd_val);
        `CHK(rd_val, 32'h00000000);
        `CHK(pend_out, 32'h00000000);
    endtask : t_freeze

    // status, mask and irq level; source pend; unmapped read
    task automatic t_irq();
        reg_wr(`IFPL_OFF_EVT_MASK, 32'h00000001);
        reg_rd(`IFPL_OFF_EVT_MASK, rd_val);
        `CHK(rd_val, 32'h00000001);
        reg_wr(`IFPL_OFF_FORCE_PEND, 32'h00000004);
        irq_is(1'b1);
        reg_rd(`IFPL_OFF_EVT_STATUS, rd_val);
        `CHK(rd_val & 32'h3, 32'h00000001);
        reg_wr(`IFPL_OFF_EVT_MASK, 32'h00000000);
        irq_is(1'b0);
        reg_wr(`IFPL_OFF_EVT_MASK, 32'h00000001);
        irq_is(1'b1);
        reg_wr(`IFPL_OFF_EVT_STATUS, 32'h00000001);
        irq_is(1'b0);
        reg_wr(`IFPL_OFF_CLEAR_PEND, 32'h00000004);
        @(posedge clk_in);
        irq_src_in <= 32'h00000020;
        repeat (4) @(posedge clk_in);
        reg_rd(`IFPL_OFF_SRC_LEVEL, rd_val);
        `CHK(rd_val, 32'h00000020);
        @(posedge clk_in);
        irq_src_in <= 32'h00000000;
        repeat (4) @(posedge clk_in);
        #1;
        `CHK(pend_out, 32'h00000020);
        reg_rd(`IFPL_OFF_CLEAR_PEND, rd_val);
        `CHK(rd_val, 32'h00000020);
        reg_wr(`IFPL_OFF_CLEAR_PEND, 32'h00000020);
        `CHK(pend_out, 32'h00000000);
        reg_rd(8'h40, rd_val);
        `CHK(rd_val, 32'h00000000);
    endtask : t_irq

    // ------------------------------------------------------------------
    // clock, main sequence and watchdog
    // ------------------------------------------------------------------
    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // reset, then scenarios in turn
    initial begin
        rst_b_in = 1'b0;
        ce_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h00000000;
        irq_src_in = 32'h00000000;
        num_errors = 0;
        checked = 0;
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_refuse_disabled();
        t_walk();
        t_zero_repeat();
        t_enable_clear();
        t_freeze();
        t_irq();
        summarize();
    end

    // the run needs about 300 cycles; cut it off well past that
    initial begin
        #100us;
        num_errors++;
        summarize();
    end
endmodule : ifpl_bank_tb
